// ==== rtl/quad_bidir_port_logic.sv ====
// Four 8-bit bidirectional ports with AXI4-Lite access to latches and pins.
// Assumes the core drives the external bus controls on core_clk and the
// pad ring resolves out, oe and pull-ups into the physical pins.
module quad_bidir_port_logic (
    input  wire logic                                        core_clk,
    input  wire logic                                        rst,
    // AXI4-Lite slave
    input  wire logic                                        awvalid,
    output logic                                             awready,
    input  wire logic [port_pkg::ADDR_W-1:0]                 awaddr,
    input  wire logic                                        wvalid,
    output logic                                             wready,
    input  wire logic [31:0]                                 wdata,
    input  wire logic [3:0]                                  wstrb,
    output logic                                             bvalid,
    input  wire logic                                        bready,
    output logic [1:0]                                       bresp,
    input  wire logic                                        arvalid,
    output logic                                             arready,
    input  wire logic [port_pkg::ADDR_W-1:0]                 araddr,
    output logic                                             rvalid,
    input  wire logic                                        rready,
    output logic [31:0]                                      rdata,
    output logic [1:0]                                       rresp,
    // Pads
    input  wire logic [port_pkg::NUM_PORTS-1:0][port_pkg::PORT_W-1:0] portIn,
    output logic [port_pkg::NUM_PORTS-1:0][port_pkg::PORT_W-1:0]      portOut,
    output logic [port_pkg::NUM_PORTS-1:0][port_pkg::PORT_W-1:0]      portOe,
    output logic [port_pkg::NUM_PORTS-1:0][port_pkg::PORT_W-1:0]      portWeakPull,
    output logic [port_pkg::NUM_PORTS-1:0][port_pkg::PORT_W-1:0]      portStrongPull,
    // External memory controls from the core
    input  wire logic                                        extAccess,
    input  wire logic                                        extWide,
    input  wire logic                                        extAddrPhase,
    input  wire logic                                        extWrite,
    input  wire logic [15:0]                                 extAddr,
    input  wire logic [7:0]                                  extWrData,
    output logic [7:0]                                       extRdData,
    // Port three alternate functions
    input  wire logic [7:0]                                  altOut,
    output logic                                             rxdIn,
    output logic                                             extIrqZero,
    output logic                                             extIrqOne,
    output logic                                             timerZeroCountInput,
    output logic                                             timerOneCountInput
);
    import port_pkg::*;

    if (NUM_PORTS != 4 || PORT_W != 8)
    begin : g_check
        $error("port block serves four 8-bit ports only");
    end

    // ==========================================================
    // Machine cycle timing
    // ==========================================================
    logic [2:0] stateFf;
    logic       phaseFf;
    logic       sampleEn;
    logic       enterS1;
    logic       latchStrobe;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stateFf <= STATE_FIRST;
            phaseFf <= PHASE_ONE;
        end
        else if (phaseFf == PHASE_TWO)
        begin
            phaseFf <= PHASE_ONE;
            stateFf <= (stateFf == STATE_LAST) ? STATE_FIRST : stateFf + 3'h1;
        end
        else
            phaseFf <= PHASE_TWO;
    end

    // Buffers load on the edge that enters phase one
    assign sampleEn    = (phaseFf == PHASE_TWO);
    assign enterS1     = sampleEn && (stateFf == STATE_LAST);
    assign latchStrobe = (phaseFf == PHASE_ONE) && (stateFf == STATE_LAST);

    // ==========================================================
    // Write channel
    // ==========================================================
    logic                 awHeldFf;
    logic [ADDR_W-1:0]    awAddrFf;
    logic                 wHeldFf;
    logic [7:0]           wDataFf;
    logic                 wLaneFf;
    logic                 wrPendFf;
    logic [1:0]           wrIdxFf;
    logic                 bvalidFf;
    logic [1:0]           brespFf;
    logic                 awIsLatch;
    logic                 wrCommit;

    assign awready   = !awHeldFf && !bvalidFf && !wrPendFf;
    assign wready    = !wHeldFf && !bvalidFf && !wrPendFf;
    assign bvalid    = bvalidFf;
    assign bresp     = brespFf;
    assign awIsLatch = (awAddrFf[ADDR_W-1:4] == LATCH_BASE[ADDR_W-1:4])
                       && (awAddrFf[1:0] == 2'h0);
    // Commit only in S6P1 so the buffers pick it up at the next S1 entry
    assign wrCommit  = wrPendFf && latchStrobe;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            awHeldFf <= 1'b0;
            awAddrFf <= '0;
            wHeldFf  <= 1'b0;
            wDataFf  <= '0;
            wLaneFf  <= 1'b0;
            wrPendFf <= 1'b0;
            wrIdxFf  <= '0;
            bvalidFf <= 1'b0;
            brespFf  <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awHeldFf <= 1'b1;
                awAddrFf <= awaddr;
            end
            if (wvalid && wready)
            begin
                wHeldFf <= 1'b1;
                wDataFf <= wdata[7:0];
                wLaneFf <= wstrb[0];
            end
            if (awHeldFf && wHeldFf)
            begin
                awHeldFf <= 1'b0;
                wHeldFf  <= 1'b0;
                if (awIsLatch && wLaneFf)
                begin
                    wrPendFf <= 1'b1;
                    wrIdxFf  <= awAddrFf[3:2];
                end
                else
                begin
                    bvalidFf <= 1'b1;
                    brespFf  <= awIsLatch ? RESP_OKAY : RESP_SLVERR;
                end
            end
            if (wrCommit)
            begin
                wrPendFf <= 1'b0;
                bvalidFf <= 1'b1;
                brespFf  <= RESP_OKAY;
            end
            if (bvalidFf && bready)
                bvalidFf <= 1'b0;
        end
    end

    // ==========================================================
    // Port latches
    // ==========================================================
    logic [NUM_PORTS-1:0][PORT_W-1:0] latchFf;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            latchFf <= {NUM_PORTS{PORT_RESET}};
        else
        begin
            if (wrCommit)
                latchFf[wrIdxFf] <= wDataFf;
            // bus cycle sets port zero to all ones, port two untouched
            // Placed last so a bus cycle beats a pending port zero write
            if (extAccess)
                latchFf[PORT_ZERO] <= PORT_RESET;
        end
    end

    // ==========================================================
    // Pad slices
    // ==========================================================
    port_pad_if padIf [NUM_PORTS] ();
    logic [NUM_PORTS-1:0][PORT_W-1:0] pinSyncAll;
    logic [NUM_PORTS-1:0]             busSelV;
    logic [NUM_PORTS-1:0]             busOeV;
    logic [NUM_PORTS-1:0][PORT_W-1:0] busDataV;

    always_comb
    begin
        busSelV  = '0;
        busOeV   = '0;
        busDataV = '0;
        // port zero time-multiplexes address and data
        busSelV[PORT_ZERO]  = extAccess;
        busOeV[PORT_ZERO]   = extAddrPhase || extWrite;
        busDataV[PORT_ZERO] = extAddrPhase ? extAddr[7:0] : extWrData;
        // port two only takes over for wide addresses
        busSelV[PORT_TWO]   = extAccess && extWide;
        busOeV[PORT_TWO]    = 1'b1;
        busDataV[PORT_TWO]  = extAddr[15:8];
    end

    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port
        assign padIf[g].latchVal = latchFf[g];
        assign padIf[g].sampleEn = sampleEn;
        assign padIf[g].enterS1  = enterS1;
        assign padIf[g].busSel   = busSelV[g];
        assign padIf[g].busOe    = busOeV[g];
        assign padIf[g].busData  = busDataV[g];
        // only port three has alternate outputs
        assign padIf[g].altOut   = (g == PORT_THREE) ? altOut : PORT_RESET;
        assign padIf[g].pinRaw   = portIn[g];
        assign pinSyncAll[g]     = padIf[g].pinSync;
        // per-bit drive, enable and pull-ups out to the pads
        assign portOut[g]        = padIf[g].padOut;
        assign portOe[g]         = padIf[g].padOe;
        assign portWeakPull[g]   = padIf[g].weakPull;
        assign portStrongPull[g] = padIf[g].strongPull;

        port_pad_slice #(
            .IS_OPEN_DRAIN (g == PORT_ZERO),
            .HAS_STRONG    (g != PORT_ZERO)
        ) u_slice (
            .core_clk (core_clk),
            .rst      (rst),
            .pad      (padIf[g])
        );
    end

    // read data returns through port zero inputs
    assign extRdData = pinSyncAll[PORT_ZERO];

    // pin level always reaches alternate inputs
    assign rxdIn               = pinSyncAll[PORT_THREE][ALT_RXD];
    assign extIrqZero          = pinSyncAll[PORT_THREE][ALT_IRQ0];
    assign extIrqOne           = pinSyncAll[PORT_THREE][ALT_IRQ1];
    assign timerZeroCountInput = pinSyncAll[PORT_THREE][ALT_TMR0];
    assign timerOneCountInput  = pinSyncAll[PORT_THREE][ALT_TMR1];

    // ==========================================================
    // Read channel
    // ==========================================================
    logic        rvalidFf;
    logic [31:0] rdataFf;
    logic [1:0]  rrespFf;

    // One read in flight: arready drops while an answer stands
    assign arready = !rvalidFf;
    assign rvalid  = rvalidFf;
    assign rdata   = rdataFf;
    assign rresp   = rrespFf;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rvalidFf <= 1'b0;
            rdataFf  <= '0;
            rrespFf  <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalidFf <= 1'b1;
            rrespFf  <= RESP_OKAY;
            rdataFf  <= '0;
            if (araddr[1:0] != 2'h0)
                rrespFf <= RESP_SLVERR;
            else if (araddr[ADDR_W-1:4] == LATCH_BASE[ADDR_W-1:4])
                rdataFf[PORT_W-1:0] <= latchFf[araddr[3:2]];
            else if (araddr[ADDR_W-1:4] == PIN_BASE[ADDR_W-1:4])
                rdataFf[PORT_W-1:0] <= pinSyncAll[araddr[3:2]];
            else if (araddr == STATUS_OFF)
            begin
                rdataFf[ST_STATE_LSB +: 3] <= stateFf;
                rdataFf[ST_PHASE_BIT]      <= phaseFf;
                rdataFf[ST_EXT_BIT]        <= extAccess;
                rdataFf[ST_PEND_BIT]       <= wrPendFf;
            end
            else
                rrespFf <= RESP_SLVERR;
        end
        else if (rvalidFf && rready)
            rvalidFf <= 1'b0;
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    resetOnes_a: assert property ($past(rst) |-> latchFf == {NUM_PORTS{PORT_RESET}})
        else $error("latches not all ones after reset");
    latchTime_a: assert property ($changed(latchFf[1]) |-> $past(latchStrobe))
        else $error("latch changed outside S6P2");
    pinAppear_a: assert property (wrCommit && wrIdxFf == 2'h1 && !extAccess
        |-> ##2 portOut[1] == $past(wDataFf, 2))
        else $error("pin not updated at S1P1");
    portZeroOnes_a: assert property (extAccess |=> latchFf[PORT_ZERO] == PORT_RESET)
        else $error("port zero latch not set by bus cycle");
    portTwoKeep_a: assert property (extAccess && !wrCommit |=> $stable(latchFf[PORT_TWO]))
        else $error("port two latch disturbed by bus cycle");
    highAddr_a: assert property (extAccess && extWide
        |-> portOut[PORT_TWO] == extAddr[15:8] && portOe[PORT_TWO] == 8'hff)
        else $error("port two not emitting high address");
    readLatch_a: assert property (arvalid && arready && araddr == LATCH_BASE
        |=> rvalid && rdata[7:0] == $past(latchFf[PORT_ZERO]))
        else $error("latch read path wrong");
    altInput_a: assert property (timerZeroCountInput == $past(portIn[PORT_THREE][ALT_TMR0], 2))
        else $error("alternate input not pin level");
    altGate_a: assert property (!busSelV[PORT_THREE] && portOut[PORT_THREE][ALT_TXD]
        |-> altOut[ALT_TXD])
        else $error("alternate output leaked");


    // Bus, read-back and pull-up checks
    wrResp_a: assert property (wrCommit |=> bvalid && bresp == RESP_OKAY)
        else $error("latch write not answered");
    busFloat_a: assert property (extAccess && !extAddrPhase && !extWrite
        |-> portOe[PORT_ZERO] == 8'h00 && portWeakPull[PORT_ZERO] == 8'h00)
        else $error("port zero not floating in bus read");
    busData_a: assert property (extAccess && !extAddrPhase && extWrite
        |-> portOut[PORT_ZERO] == extWrData && portOe[PORT_ZERO] == 8'hff)
        else $error("port zero not driving write data");
    rdPath_a: assert property (extRdData == $past(portIn[PORT_ZERO], 2))
        else $error("bus read data not from port zero pins");
    weakTrack_a: assert property (!busSelV[1] |-> portWeakPull[1] == ~portOe[1])
        else $error("weak pull-up on while pulling low");
    statusExt_a: assert property (arvalid && arready && araddr == STATUS_OFF
        |=> rdata[ST_EXT_BIT] == $past(extAccess))
        else $error("status bus bit wrong");

    latchWrite_c: cover property (wrCommit);
    busWide_c:    cover property (extAccess && extWide && extAddrPhase);
    pinRead_c:    cover property (arvalid && arready && araddr[ADDR_W-1:4] == PIN_BASE[ADDR_W-1:4]);
    busRead_c:    cover property (extAccess && !extAddrPhase && !extWrite);
endmodule : quad_bidir_port_logic

// ==== rtl/port_pkg.sv ====
// Constants for the four-port bidirectional I/O block.
// Assumes one 20 MHz core clock and an AXI4-Lite master on the register side.
package port_pkg;
    localparam int        NUM_PORTS   = 4;
    localparam int        PORT_W      = 8;
    localparam int        ADDR_W      = 8;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam int        PORT_ZERO   = 0;
    localparam int        PORT_TWO    = 2;
    localparam int        PORT_THREE  = 3;
    // Register map, byte addresses
    localparam logic [7:0] LATCH_BASE = 8'h00;
    localparam logic [7:0] PIN_BASE   = 8'h10;
    localparam logic [7:0] STATUS_OFF = 8'h20;
    // Status layout
    localparam int        ST_STATE_LSB = 0;
    localparam int        ST_PHASE_BIT = 3;
    localparam int        ST_EXT_BIT   = 4;
    localparam int        ST_PEND_BIT  = 5;
    // Machine cycle: six states of two phases
    localparam logic [2:0] STATE_FIRST = 3'h0;
    localparam logic [2:0] STATE_LAST  = 3'h5;
    localparam logic       PHASE_ONE   = 1'b0;
    localparam logic       PHASE_TWO   = 1'b1;
    // Port three alternate bit positions
    localparam int        ALT_RXD   = 0;
    localparam int        ALT_TXD   = 1;
    localparam int        ALT_IRQ0  = 2;
    localparam int        ALT_IRQ1  = 3;
    localparam int        ALT_TMR0  = 4;
    localparam int        ALT_TMR1  = 5;
    localparam int        ALT_WRSTB = 6;
    localparam int        ALT_RDSTB = 7;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : port_pkg

// ==== rtl/port_pad_if.sv ====
// Carrier between the port core and one pad slice.
// Assumes both ends run on core_clk.
interface port_pad_if;
    logic [7:0] latchVal;
    logic       sampleEn;
    logic       enterS1;
    logic       busSel;
    logic       busOe;
    logic [7:0] busData;
    logic [7:0] altOut;
    logic [7:0] pinRaw;
    logic [7:0] pinSync;
    logic [7:0] padOut;
    logic [7:0] padOe;
    logic [7:0] weakPull;
    logic [7:0] strongPull;
    modport ctrl (output latchVal, sampleEn, enterS1, busSel, busOe, busData, altOut,
                  pinRaw, input pinSync, padOut, padOe, weakPull, strongPull);
    modport pad  (input latchVal, sampleEn, enterS1, busSel, busOe, busData, altOut,
                  pinRaw, output pinSync, padOut, padOe, weakPull, strongPull);
endinterface : port_pad_if

// ==== rtl/port_pad_slice.sv ====
// Output buffer, pull-up control and input synchroniser for one 8-bit port.
// Assumes sampleEn marks the last phase-two cycle before each phase one.
module port_pad_slice #(
    parameter bit IS_OPEN_DRAIN = 1'b0,
    parameter bit HAS_STRONG    = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    port_pad_if.pad  pad
);
    import port_pkg::*;

    logic [7:0] bufFf;
    logic [7:0] syncOneFf;
    logic [7:0] syncTwoFf;
    logic [7:0] strongFf;
    logic [7:0] drive;

    // two-stage synchroniser
    // No reset: tracks pins through reset, so no false edge follows it
    always_ff @(posedge core_clk)
    begin
        syncOneFf <= pad.pinRaw;
        syncTwoFf <= syncOneFf;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            bufFf <= PORT_RESET;
        else if (pad.sampleEn)
            bufFf <= pad.latchVal;
    end

    // strong pull for S1 on rise
    always_ff @(posedge core_clk)
    begin
        if (rst)
            strongFf <= '0;
        else if (pad.sampleEn)
            strongFf <= (HAS_STRONG && pad.enterS1) ? (pad.latchVal & ~bufFf) : 8'h00;
    end

    // latch zero forces alternate output low
    assign drive = bufFf & pad.altOut;

    always_comb
    begin
        if (pad.busSel)
        begin
            pad.padOut     = pad.busData;
            pad.padOe      = {8{pad.busOe}};
            pad.weakPull   = 8'h00;
            pad.strongPull = 8'h00;
        end
        else
        begin
            pad.padOut     = drive;
            pad.padOe      = ~drive;
            pad.weakPull   = IS_OPEN_DRAIN ? 8'h00 : drive;
            pad.strongPull = IS_OPEN_DRAIN ? 8'h00 : (strongFf & drive);
        end
    end

    assign pad.pinSync = syncTwoFf;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    syncDelay_a: assert property (pad.pinSync == $past(pad.pinRaw, 2))
        else $error("pin sync delay not two cycles");
    holdPhase_a: assert property (!pad.sampleEn |=> $stable(bufFf))
        else $error("buffer changed outside phase one");
    strongWidth_a: assert property ($rose(|strongFf) |-> ##1 (|strongFf) ##1 !(|strongFf))
        else $error("strong pull not exactly two cycles");
    zeroDrives_a: assert property (pad.sampleEn && !pad.busSel && pad.latchVal == 8'h00
        ##1 !pad.busSel |-> pad.padOe == 8'hff)
        else $error("zero latch not driven low");
    odFloat_a: assert property (IS_OPEN_DRAIN |-> pad.weakPull == 8'h00)
        else $error("open drain port pulled up");
    strongSeen_c: cover property ($rose(|strongFf));
endmodule : port_pad_slice

// ==== testbench/port_pin_model.sv ====
// Pin loads and external drivers on the four ports.
// Assumes the bench drives only pins whose latch holds one.
module port_pin_model (
    input  wire logic        core_clk,
    input  wire logic [31:0] drvOut,
    input  wire logic [31:0] drvOe,
    input  wire logic [31:0] pullUp,
    input  wire logic [31:0] extVal,
    input  wire logic [31:0] extOe,
    output logic      [31:0] pinLvl
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] lastLvl_ff = 32'h0;
    // ========================================
    // Wire resolution
    // outside drive only on released pins; a float flips each cycle
    assign pinLvl = (drvOe & drvOut) | (~drvOe & extOe & extVal)
                  | (~drvOe & ~extOe & (pullUp | ~lastLvl_ff));
    always_ff @(posedge core_clk)
    begin
        // Toggles by itself so an unknown level cannot lock a float pin
        lastLvl_ff <= ~lastLvl_ff;
    end
endmodule : port_pin_model

// ==== testbench/quad_bidir_port_logic_tb_top.sv ====
// Self-checking bench for the four-port block over AXI4-Lite.
// Assumes the pin model closes the pads; seed fixed for repeatable runs.
`define CHK(g, w) begin check_count++; if ((g) !== (w)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module quad_bidir_port_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import port_pkg::*;
    logic core_clk, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, altOut = 8'hff, extWrData = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, extVal = 32'h0, extOe = 32'h0, pinLvl;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    logic extAccess = 1'b0, extWide = 1'b0, extAddrPhase = 1'b0, extWrite = 1'b0;
    logic [15:0] extAddr = 16'h0;
    logic [7:0] extRdData;
    logic [4:0] altIn;
    logic [3:0][7:0] portOut, portOe, portWeakPull, portStrongPull;
    int err_count = 0;
    int check_count = 0;
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    quad_bidir_port_logic i_quad_bidir_port_logic (.core_clk(core_clk), .rst(rst),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .portIn(pinLvl),
        .portOut(portOut), .portOe(portOe), .portWeakPull(portWeakPull),
        .portStrongPull(portStrongPull), .extAccess(extAccess), .extWide(extWide),
        .extAddrPhase(extAddrPhase), .extWrite(extWrite), .extAddr(extAddr),
        .extWrData(extWrData), .extRdData(extRdData), .altOut(altOut), .rxdIn(altIn[0]),
        .extIrqZero(altIn[1]), .extIrqOne(altIn[2]), .timerZeroCountInput(altIn[3]),
        .timerOneCountInput(altIn[4]));
    port_pin_model i_port_pin_model (.core_clk(core_clk), .drvOut(portOut),
        .drvOe(portOe), .pullUp(portWeakPull | portStrongPull), .extVal(extVal),
        .extOe(extOe), .pinLvl(pinLvl));
    // ========================================
    // Bus tasks and expectations
    task automatic axiWr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge core_clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(posedge core_clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axiWr
    task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axiRd
    // Port three pulls low where latch or alternate output is zero
    function automatic logic [7:0] expOe(input int p, input logic [7:0] v, input logic [7:0] a);
        return (p == PORT_THREE) ? ~(v & a) : ~v;
    endfunction : expOe
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        print_verdict();
    end
    // ========================================
    // Tests
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] v, w;
        logic [15:0] ea;
        logic [7:0] prv [NUM_PORTS] = '{default: 8'hff};
        int p;
        void'($urandom(32'hb5503c55));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            axiRd(LATCH_BASE + 8'(4 * i), d, r);
            `CHK({r, d}, {RESP_OKAY, 32'hff})
        end
        $display("test reset done");
        for (int k = 0; k < 9; k++)
        begin
            p = 1 + k % 3;
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            altOut <= 8'($urandom);
            axiWr(LATCH_BASE + 8'(4 * p), v, r);
            @(negedge core_clk);
            `CHK(portStrongPull[p], v & ~prv[p] & (p == PORT_THREE ? altOut : 8'hff))
            prv[p] = v;
            axiRd(LATCH_BASE + 8'(4 * p), d, r);
            `CHK(d, {24'h0, v})
            repeat (4) @(posedge core_clk);
            `CHK(portOe[p], expOe(p, v, altOut))
            `CHK(portWeakPull[p], ~expOe(p, v, altOut))
            axiRd(PIN_BASE + 8'(4 * p), d, r);
            `CHK(d[7:0], ~expOe(p, v, altOut))
        end
        $display("test latch and pin done");
        axiWr(LATCH_BASE + 8'hc, 8'hff, r);
        altOut <= 8'hff;
        extOe <= 32'h3d000000;
        extVal <= $urandom;
        repeat (6) @(posedge core_clk);
        `CHK(altIn, {extVal[29:26], extVal[24]})
        extOe <= 32'h0;
        axiWr(8'h30, 8'h00, r);
        `CHK(r, RESP_SLVERR)
        axiRd(8'h30, d, r);
        `CHK(r, RESP_SLVERR)
        $display("test alternate inputs and unmapped done");
        // bus sets port zero latch to ones, port two left alone while the bus runs
        axiWr(LATCH_BASE, 8'h00, r);
        w = 8'($urandom);
        axiWr(LATCH_BASE + 8'h8, w, r);
        ea = 16'($urandom);
        v = 8'($urandom);
        extAddr <= ea;
        extAccess <= 1'b1;
        extWide <= 1'b1;
        extAddrPhase <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK({portOut[2], portOe[2]}, {ea[15:8], 8'hff})
        `CHK({portOut[0], portOe[0]}, {ea[7:0], 8'hff})
        `CHK(pinLvl[7:0], ea[7:0])
        extAddrPhase <= 1'b0;
        extWrite <= 1'b1;
        extWrData <= v;
        extWide <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK({portOut[0], portOe[0]}, {v, 8'hff})
        `CHK(portOe[2], ~w)
        extWrite <= 1'b0;
        extOe <= 32'hff;
        extVal <= $urandom;
        repeat (3) @(posedge core_clk);
        `CHK({portOe[0], portWeakPull[0], extRdData}, {16'h0, extVal[7:0]})
        axiRd(STATUS_OFF, d, r);
        `CHK({r, d[31:ST_EXT_BIT]}, {RESP_OKAY, 28'h1})
        extAccess <= 1'b0;
        extOe <= 32'h0;
        axiRd(LATCH_BASE, d, r);
        `CHK(d, 32'hff)
        axiRd(LATCH_BASE + 8'h8, d, r);
        `CHK(d, {24'h0, w})
        $display("test external bus done");
        print_verdict();
    end
endmodule : quad_bidir_port_logic_tb_top
